// ===== rtl/timer_mode_control.sv
`timescale 1ns/1ns
`include "timer_mode_defines.svh"
module timer_mode_control (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// AXI4-Lite write channels.
	input  wire logic [13:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [13:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Timer input sources, asynchronous.
	input  wire logic        timer_in_pin,
	input  wire logic        comparator_out,
	// Timer outputs and interrupt event.
	output timer_mode_pkg::timer_out_t timer_out,
	output logic             timer_irq
);
	timer_mode_pkg::cfg_ctrl_t cfg_q;
	timer_mode_pkg::op_ctrl_t  op_q;
	timer_mode_pkg::op_mode_t  mode;
	logic [15:0] count_q;
	logic [15:0] reload_q;
	logic [15:0] compare_q;
	logic [1:0]  pin_sync_q;
	logic [1:0]  cmp_sync_q;
	logic        in_lvl;
	logic        in_prev_q;
	logic        edge_act;
	logic        edge_inact;
	logic [6:0]  clock_divider_sel_q;
	logic        tick;
	logic        started_q;
	logic        armed_q;
	logic        run;
	logic        reload_ev;
	logic        match_ev;
	logic        capture_ev;
	logic        raw_q;
	logic        raw_d;
	logic        out_q;
	logic        out_n_q;
	logic [7:0]  dly_q;
	logic [7:0]  dly_n_q;
	logic        irq_q;
	logic        irq_reload;
	logic        irq_cap;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic        bvalid_q;
	logic        rvalid_q;
	logic [13:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_fire;

	function automatic logic [7:0] delay_cycles(input logic [2:0] code);
		// Zero for code 0, else two to the code.
		delay_cycles = (code == 3'h0) ? 8'h00 : (8'h01 << code); // [R6] [R24]
	endfunction

	function automatic logic div_due(input logic [6:0] cnt,
		input logic [2:0] sel);
		// Code 7 wraps the shift to zero, giving the full seven-bit mask.
		div_due = (cnt & ((7'h01 << sel) - 7'h01)) == 7'h00; // [R20]
	endfunction

	function automatic logic is_capture_mode(input logic [3:0] m);
		is_capture_mode = (m == 4'h4) || (m == 4'h7) || (m == 4'h9);
	endfunction

	assign mode = timer_mode_pkg::op_mode_t'({cfg_q.mode3, op_q.mode_low}); // [R1]
	assign run = op_q.timer_run; // [R9]

	// Two flops on each asynchronous input before anything looks at it.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_sync_q <= 2'h0;
			cmp_sync_q <= 2'h0;
		end else begin
			pin_sync_q <= {pin_sync_q[0], timer_in_pin};
			cmp_sync_q <= {cmp_sync_q[0], comparator_out};
		end
	end

	assign in_lvl = cfg_q.input_source_select ? cmp_sync_q[1]
		: pin_sync_q[1]; // [R5]

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			in_prev_q <= 1'b0;
		else
			in_prev_q <= in_lvl;
	end

	// Active edge is rising for polarity 0 and falling for polarity 1.
	assign edge_act = op_q.io_polarity ? (in_prev_q & ~in_lvl)
		: (~in_prev_q & in_lvl); // [R13] [R14] [R19]
	assign edge_inact = op_q.io_polarity ? (~in_prev_q & in_lvl)
		: (in_prev_q & ~in_lvl); // [R15]

	// Prescaler, held clear while disabled so each run starts aligned.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			clock_divider_sel_q <= 7'h00;
		else if (!run)
			clock_divider_sel_q <= 7'h00; // [R21]
		else
			clock_divider_sel_q <= clock_divider_sel_q + 7'h01;
	end

	always_comb begin
		tick = 1'b0;
		if (run) begin
			case (mode)
				timer_mode_pkg::MODE_COUNTER,
				timer_mode_pkg::MODE_CMP_COUNTER:
					tick = edge_act; // [R13]
				// Code 0101 is gated; codes above 1011 fall to default.
				timer_mode_pkg::MODE_GATED:
					tick = (in_lvl != op_q.io_polarity) && // [R15] [R25]
						div_due(clock_divider_sel_q, op_q.clock_divider_sel);
				timer_mode_pkg::MODE_CAP_CMP,
				timer_mode_pkg::MODE_TRIG_ONE_SHOT:
					tick = started_q && // [R16] [R19]
						div_due(clock_divider_sel_q, op_q.clock_divider_sel);
				default:
					tick = div_due(clock_divider_sel_q, op_q.clock_divider_sel);
			endcase
		end
	end

	// Start latch for edge-started modes.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			started_q <= 1'b0;
		else if (!run)
			started_q <= 1'b0;
		else if ((mode == timer_mode_pkg::MODE_CAP_CMP ||
			mode == timer_mode_pkg::MODE_TRIG_ONE_SHOT) && edge_act)
			started_q <= 1'b1; // [R16] [R19]
		else if (mode == timer_mode_pkg::MODE_TRIG_ONE_SHOT && reload_ev)
			started_q <= 1'b0;
	end

	assign reload_ev = tick && (count_q == reload_q); // [R23]
	assign match_ev = run && tick && (count_q == compare_q);
	assign capture_ev = run && edge_act && (is_capture_mode(mode) ||
		mode == timer_mode_pkg::MODE_CMP_COUNTER) &&
		(mode != timer_mode_pkg::MODE_CAP_CMP || started_q); // [R14] [R16]

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			armed_q <= 1'b0;
		else
			armed_q <= run && mode == timer_mode_pkg::MODE_ONE_SHOT &&
				reload_ev; // [R11]
	end

	// Interrupt source selection.
	always_comb begin
		irq_reload = 1'b0;
		irq_cap = 1'b0;
		case (mode)
			timer_mode_pkg::MODE_GATED: begin
				irq_reload = reload_ev &&
					cfg_q.irq_source_config != 2'h2; // [R3]
				irq_cap = edge_inact && run &&
					cfg_q.irq_source_config != 2'h3; // [R3] [R15]
			end
			timer_mode_pkg::MODE_CAPTURE,
			timer_mode_pkg::MODE_CAP_CMP,
			timer_mode_pkg::MODE_CAP_RESTART: begin
				irq_reload = reload_ev &&
					cfg_q.irq_source_config != 2'h2; // [R4]
				irq_cap = capture_ev &&
					cfg_q.irq_source_config != 2'h3; // [R4]
			end
			default:
				irq_reload = reload_ev &&
					cfg_q.irq_source_config != 2'h2; // [R2]
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			irq_q <= 1'b0;
		else
			irq_q <= irq_reload | irq_cap;
	end
	assign timer_irq = irq_q;

	// Counter, reload and compare storage.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= `COUNT_RESET;
		end else if (wr_fire && awaddr_q == `ADDR_COUNT) begin
			count_q <= wdata_q[15:0];
		end else if (mode == timer_mode_pkg::MODE_CAP_RESTART && capture_ev) begin
			count_q <= `COUNT_START;
		end else if (reload_ev) begin
			count_q <= `COUNT_START; // [R23]
		end else if (tick) begin
			count_q <= count_q + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			reload_q <= `RELOAD_RESET;
		else if (wr_fire && awaddr_q == `ADDR_RELOAD)
			reload_q <= wdata_q[15:0];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			compare_q <= `COMPARE_RESET;
		else if (capture_ev)
			compare_q <= count_q; // [R22]
		else if (wr_fire && awaddr_q == `ADDR_COMPARE)
			compare_q <= wdata_q[15:0];
	end

	// Raw output level before dead-band shaping.
	always_comb begin
		raw_d = raw_q;
		if (!run)
			raw_d = op_q.io_polarity; // [R10]
		else begin
			case (mode)
				timer_mode_pkg::MODE_ONE_SHOT:
					raw_d = op_q.io_polarity ^ armed_q; // [R11]
				timer_mode_pkg::MODE_PWM_SINGLE,
				timer_mode_pkg::MODE_PWM_DUAL:
					if (reload_ev)
						raw_d = op_q.io_polarity; // [R17] [R18]
					else if (match_ev)
						raw_d = ~op_q.io_polarity; // [R17]
				default:
					if (reload_ev)
						raw_d = ~raw_q; // [R12]
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			raw_q <= 1'b0;
		else
			raw_q <= raw_d;
	end

	// Dead-band: rising edges wait while the timer runs, falling edges pass at once.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_q <= 1'b0;
			dly_q <= 8'h00;
		end else if (!raw_q || !run) begin
			out_q <= raw_q; // [R7] [R10]
			dly_q <= delay_cycles(cfg_q.deadband_delay);
		end else if (dly_q != 8'h00) begin
			dly_q <= dly_q - 8'h01; // [R6]
		end else begin
			out_q <= 1'b1; // [R7]
		end
	end

	// The complement shares the delay so a gap opens at every crossover when the delay code is nonzero.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_n_q <= 1'b0;
			dly_n_q <= 8'h00;
		end else if (!run || mode != timer_mode_pkg::MODE_PWM_DUAL) begin
			out_n_q <= 1'b0;
			dly_n_q <= delay_cycles(cfg_q.deadband_delay);
		end else if (raw_q) begin
			out_n_q <= 1'b0; // [R7] [R18]
			dly_n_q <= delay_cycles(cfg_q.deadband_delay);
		end else if (dly_n_q != 8'h00) begin
			dly_n_q <= dly_n_q - 8'h01; // [R6]
		end else begin
			out_n_q <= 1'b1; // [R18]
		end
	end

	assign timer_out.out = out_q;
	assign timer_out.out_n = out_n_q;

	// AXI4-Lite write path: address and data accepted in either order.
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign wr_fire = aw_hold_q && w_hold_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			bvalid_q <= 1'b0;
			awaddr_q <= 14'h0000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = 2'h0;

	// Control registers; the capture flag is hardware-owned and read-only.
	// Each control register sits at four times its index, one word each.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= `CFG_RESET;
			op_q <= `OP_RESET;
		end else begin
			if (wr_fire && wstrb_q[0] && awaddr_q == `ADDR_CFG_CTRL)
				cfg_q[7:1] <= wdata_q[7:1];
			if (irq_reload || irq_cap)
				cfg_q.capture_irq_flag <= irq_cap &&
					is_capture_mode(mode); // [R8]
			if (wr_fire && wstrb_q[0] && awaddr_q == `ADDR_OP_CTRL)
				op_q <= wdata_q[7:0];
		end
	end

	// AXI4-Lite read path, one cycle to the answer.
	assign s_axi_arready = !rvalid_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			case (s_axi_araddr)
				`ADDR_CFG_CTRL: rdata_q <= {24'h000000, cfg_q};
				`ADDR_OP_CTRL:  rdata_q <= {24'h000000, op_q};
				`ADDR_COUNT:    rdata_q <= {16'h0000, count_q};
				`ADDR_RELOAD:   rdata_q <= {16'h0000, reload_q};
				`ADDR_COMPARE:  rdata_q <= {16'h0000, compare_q};
				default:        rdata_q <= 32'h0000_0000;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = 2'h0;
endmodule

// ===== rtl/timer_mode_defines.svh
// Summary of operation
// (R1) Four-bit mode code split across registers.
// (R2) Reload interrupt unless field is 10.
// (R3) Gated: reload and/or inactive gate edge.
// (R4) Capture modes: reload and/or capture interrupt.
// (R5) Input from pin or comparator by select.
// (R6) Dead-band delay doubles per code, 0..128.
// (R7) Delay only rising edges of both outputs.
// (R8) Read-only flag marks capture-caused interrupt.
// (R9) Timer runs only while enable bit set.
// (R10) Disabled output equals polarity bit.
// (R11) One-shot output pulses one clock after reload.
// (R12) Other modes toggle output on reload.
// (R13) Counter counts polarity-selected input edges.
// (R14) Capture modes capture on selected edge.
// (R15) Gated counts while input equals active level.
// (R16) Capture/compare starts first edge, captures later.
// (R17) PWM single: set at match, back at reload.
// (R18) PWM dual: complement output is opposite.
// (R19) Triggered one-shot starts on selected edge.
// (R20) Prescaler divides by two to the field.
// (R21) Prescaler cleared while timer disabled.
// (R22) Captured count stored in compare register pair.
// (R23) Reload value is max; reload to 0001.
// (R24) Delay code 110 means 64 cycles.
// (R25) Code 0101 gated; 1100-1111 reserved.
`ifndef TIMER_MODE_DEFINES_SVH
`define TIMER_MODE_DEFINES_SVH
`define IDX_CFG_CTRL       12'hf06
`define IDX_OP_CTRL        12'hf07
`define ADDR_CFG_CTRL      {`IDX_CFG_CTRL, 2'h0}
`define ADDR_OP_CTRL       {`IDX_OP_CTRL, 2'h0}
`define ADDR_COUNT         14'h0000
`define ADDR_RELOAD        14'h0004
`define ADDR_COMPARE       14'h0008
`define CFG_RESET          8'h00
`define OP_RESET           8'h00
`define RELOAD_RESET       16'hffff
`define COUNT_RESET        16'h0001
`define COMPARE_RESET      16'h0000
`define COUNT_START        16'h0001
`define CFG_MODE3_BIT      7
`define CFG_IRQ_HI         6
`define CFG_IRQ_LO         5
`define CFG_INSEL_BIT      4
`define CFG_DLY_HI         3
`define CFG_DLY_LO         1
`define CFG_CAP_BIT        0
`define OP_RUN_BIT         7
`define OP_POL_BIT         6
`define OP_DIV_HI          5
`define OP_DIV_LO          3
`define OP_MODE_HI         2
`define OP_MODE_LO         0
`endif

// ===== rtl/timer_mode_pkg.sv
package timer_mode_pkg;
	typedef enum logic [3:0] {
		MODE_ONE_SHOT   = 4'h0,
		MODE_CONTINUOUS = 4'h1,
		MODE_COUNTER    = 4'h2,
		MODE_PWM_SINGLE = 4'h3,
		MODE_CAPTURE    = 4'h4,
		MODE_GATED      = 4'h5,
		MODE_COMPARE    = 4'h6,
		MODE_CAP_CMP    = 4'h7,
		MODE_PWM_DUAL   = 4'h8,
		MODE_CAP_RESTART = 4'h9,
		MODE_CMP_COUNTER = 4'ha,
		MODE_TRIG_ONE_SHOT = 4'hb
	} op_mode_t;
	typedef struct packed {
		logic       mode3;
		logic [1:0] irq_source_config;
		logic       input_source_select;
		logic [2:0] deadband_delay;
		logic       capture_irq_flag;
	} cfg_ctrl_t;
	typedef struct packed {
		logic       timer_run;
		logic       io_polarity;
		logic [2:0] clock_divider_sel;
		logic [2:0] mode_low;
	} op_ctrl_t;
	typedef struct packed {
		logic       out;
		logic       out_n;
	} timer_out_t;
endpackage

// ===== testbench/timer_mode_control_checker.sv
`timescale 1ns/1ns
module timer_mode_control_checker (
	// Clock and reset.
	input wire logic                       ref_clk,
	input wire logic                       arst_n,
	// Register bus.
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	// Timer outputs.
	input wire timer_mode_pkg::timer_out_t timer_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write response dropped early");
	a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	a_write_block: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write taken early");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read response late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	a_read_block: assert property (s_axi_rvalid |->
		!s_axi_arready && s_axi_rresp == 2'h0) else $error("read refused");
	a_no_overlap: assert property (!(timer_out.out && timer_out.out_n))
		else $error("output and complement both active");
endmodule
bind timer_mode_control timer_mode_control_checker chk_u (.*);

// ===== testbench/timer_mode_control_tb.sv
`timescale 1ns/1ns
`include "timer_mode_defines.svh"
module timer_mode_control_tb;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [13:0] s_axi_awaddr = 14'h0000;
	logic [13:0] s_axi_araddr = 14'h0000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, use_cmp = 1'b0, start = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, timer_irq, busy;
	logic        timer_in_pin, comparator_out;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, c1, c2;
	logic [7:0]  n_pulses = 8'h00;
	int          mismatches = 0, n_tests = 0, cyc = 0, n_irq = 0;
	timer_mode_pkg::timer_out_t timer_out;
	always #5 ref_clk = ~ref_clk;
	timer_mode_control dut_u (.*);
	timer_source_model src_u (.*);
	always @(negedge ref_clk) if (timer_irq === 1'b1) n_irq = n_irq + 1;
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [13:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!hb) begin
			@(negedge ref_clk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			@(posedge ref_clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [13:0] a, output logic [31:0] d);
		logic hr, hd;
		hd = 1'b0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!hd) begin
			@(negedge ref_clk);
			hr = s_axi_arvalid && s_axi_arready;
			hd = s_axi_rvalid;
			d = s_axi_rdata;
			@(posedge ref_clk);
			if (hr) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	task automatic set_op(input logic r, p, input logic [2:0] dv, m);
		wr(`ADDR_OP_CTRL, {24'h0, r, p, dv, m});
	endtask
	task automatic pulse(input logic [7:0] n);
		@(posedge ref_clk);
		n_pulses <= n;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		do @(negedge ref_clk); while (busy);
		repeat (8) @(negedge ref_clk);
	endtask
	task automatic prep(input logic [31:0] rl, cf);
		wr(`ADDR_RELOAD, rl);
		wr(`ADDR_CFG_CTRL, cf);
		wr(`ADDR_COUNT, 32'h1);
	endtask
	task automatic watch(input int n, output int nh, n2, nn);
		logic pv;
		nh = 0;
		n2 = 0;
		nn = 0;
		pv = 1'b0;
		repeat (n) begin
			@(negedge ref_clk);
			nh += timer_out.out;
			n2 += timer_out.out && pv;
			nn += timer_out.out_n;
			pv = timer_out.out;
		end
	endtask
	task automatic t_gated;
		prep(32'hffff, 32'h40);
		set_op(1'b1, 1'b0, 3'h0, 3'h5);
		n_irq = 0;
		pulse(8'h03);
		check(32'(n_irq), 32'h3);
		rd(`ADDR_COUNT, c1); check(c1, 32'hd);
		rd(`ADDR_CFG_CTRL, c1); check(c1, 32'h40);
		set_op(1'b0, 1'b0, 3'h0, 3'h5);
	endtask
	task automatic t_restart;
		prep(32'hffff, 32'hc0);
		set_op(1'b1, 1'b0, 3'h0, 3'h1);
		n_irq = 0;
		pulse(8'h02);
		check(32'(n_irq), 32'h2);
		rd(`ADDR_COMPARE, c1); check(c1, 32'h8);
		set_op(1'b0, 1'b0, 3'h0, 3'h1);
	endtask
	task automatic t_wave;
		int nh, n2, nn;
		prep(32'h3, 32'h0);
		set_op(1'b1, 1'b0, 3'h0, 3'h0);
		watch(30, nh, n2, nn);
		check(32'(nh >= 9 && nh <= 11 && n2 == 0), 32'h1);
		prep(32'h14, 32'h0);
		wr(`ADDR_COMPARE, 32'ha);
		set_op(1'b1, 1'b0, 3'h0, 3'h3);
		watch(100, nh, n2, nn);
		check(32'(nh >= 45 && nh <= 55 && nn == 0), 32'h1);
		set_op(1'b0, 1'b0, 3'h0, 3'h3);
	endtask
	task automatic t_trig;
		prep(32'h5, 32'h80);
		set_op(1'b1, 1'b0, 3'h0, 3'h3);
		rd(`ADDR_COUNT, c1); check(c1, 32'h1);
		pulse(8'h01);
		rd(`ADDR_COUNT, c1); check(c1, 32'h1);
		check(32'(timer_out.out), 32'h1);
		set_op(1'b0, 1'b0, 3'h0, 3'h3);
	endtask
	task automatic t_regs;
		rd(`ADDR_CFG_CTRL, c1); check(c1, 32'h0);
		rd(`ADDR_OP_CTRL, c1); check(c1, 32'h0);
		rd(`ADDR_RELOAD, c1); check(c1, 32'hffff);
		wr(14'h0100, 32'h5a);
		rd(14'h0100, c1); check(c1, 32'h0);
		wr(`ADDR_CFG_CTRL, 32'hff);
		rd(`ADDR_CFG_CTRL, c1); check(c1, 32'hfe);
		wr(`ADDR_CFG_CTRL, 32'h0);
		set_op(1'b0, 1'b1, 3'h0, 3'h0);
		repeat (3) @(negedge ref_clk);
		check(32'(timer_out.out), 32'h1);
		set_op(1'b0, 1'b0, 3'h0, 3'h0);
		repeat (3) @(negedge ref_clk);
		check(32'(timer_out.out), 32'h0);
	endtask
	task automatic t_cont(input logic [1:0] ic, input logic [2:0] dv, int ex);
		int nt, ni;
		logic pv;
		nt = 0;
		wr(`ADDR_CFG_CTRL, {24'h0, 1'b0, ic, 5'h00});
		wr(`ADDR_COUNT, 32'h1);
		set_op(1'b1, 1'b0, dv, 3'h1);
		n_irq = 0;
		pv = timer_out.out;
		repeat (120) begin
			@(negedge ref_clk);
			nt += (timer_out.out !== pv);
			pv = timer_out.out;
		end
		ni = n_irq;
		set_op(1'b0, 1'b0, 3'h0, 3'h1);
		check(32'(nt >= ex - 1 && nt <= ex + 1), 32'h1);
		nt = ic == 2'h2 ? ni == 0 : (ni >= ex - 1 && ni <= ex + 1);
		check(32'(nt), 32'h1);
	endtask
	task automatic t_count(input logic p, s, input logic [7:0] n);
		wr(`ADDR_CFG_CTRL, {24'h0, 3'h0, s, 4'h0});
		use_cmp <= s;
		wr(`ADDR_COUNT, 32'h1);
		set_op(1'b1, p, 3'h0, 3'h2);
		pulse(n);
		rd(`ADDR_COUNT, c1); check(c1, 32'h1 + n);
		set_op(1'b0, 1'b0, 3'h0, 3'h2);
	endtask
	task automatic t_capture;
		wr(`ADDR_CFG_CTRL, 32'h40);
		wr(`ADDR_COUNT, 32'h1);
		set_op(1'b1, 1'b0, 3'h0, 3'h4);
		n_irq = 0;
		pulse(8'h01);
		rd(`ADDR_CFG_CTRL, c1); check(c1, 32'h41);
		check(32'(n_irq), 32'h1);
		rd(`ADDR_COMPARE, c1); check(32'(c1 != 32'h0), 32'h1);
		set_op(1'b0, 1'b0, 3'h0, 3'h4);
		rd(`ADDR_COUNT, c1);
		pulse(8'h02);
		rd(`ADDR_COUNT, c2); check(c2, c1);
	endtask
	task automatic t_dual;
		int no, nn, ng;
		no = 0;
		nn = 0;
		ng = 0;
		wr(`ADDR_RELOAD, 32'h14);
		wr(`ADDR_COMPARE, 32'ha);
		wr(`ADDR_CFG_CTRL, 32'h82);
		wr(`ADDR_COUNT, 32'h1);
		set_op(1'b1, 1'b0, 3'h0, 3'h0);
		repeat (100) begin
			@(negedge ref_clk);
			no += timer_out.out;
			nn += timer_out.out_n;
			ng += !timer_out.out && !timer_out.out_n;
		end
		set_op(1'b0, 1'b0, 3'h0, 3'h0);
		check(32'(no > 0 && nn > 0), 32'h1);
		check(32'(ng >= 10 && ng <= 30), 32'h1);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_regs();
		wr(`ADDR_RELOAD, 32'h3);
		t_cont(2'h0, 3'h0, 40);
		t_cont(2'h2, 3'h0, 40);
		t_cont(2'h3, 3'h1, 20);
		wr(`ADDR_RELOAD, 32'hffff);
		t_count(1'b0, 1'b0, 8'h05);
		t_count(1'b1, 1'b0, 8'h03);
		t_count(1'b0, 1'b1, 8'h04);
		use_cmp <= 1'b0;
		t_capture();
		t_gated();
		t_restart();
		t_dual();
		t_wave();
		t_trig();
		stop_test();
	end
endmodule

// ===== testbench/timer_source_model.sv
`timescale 1ns/1ns
module timer_source_model (
	// Control from the bench.
	input wire logic       ref_clk,
	input wire logic       use_cmp,
	input wire logic       start,
	input wire logic [7:0] n_pulses,
	output logic           busy,
	// Input lines of the block.
	output logic           timer_in_pin,
	output logic           comparator_out
);
	logic [7:0] left_q = 8'h00;
	logic [2:0] ph_q = 3'h0;
	logic       noise_q = 1'b0;
	logic       lvl;
	// The unused line toggles every cycle so a wrong select shows at once.
	always_ff @(posedge ref_clk) begin
		noise_q <= !noise_q;
		if (start && !busy) begin
			left_q <= n_pulses;
			ph_q <= 3'h0;
		end else if (left_q != 8'h00) begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h7)
				left_q <= left_q - 8'h01;
		end
	end
	assign busy = left_q != 8'h00;
	assign lvl = busy && !ph_q[2];
	assign timer_in_pin = use_cmp ? noise_q : lvl;
	assign comparator_out = use_cmp ? lvl : noise_q;
endmodule
